//--- design/eo_lpi_pkg.sv
// package of constants and types for the low power idle electro-optic control block
// Behaviour
// - one transmit sample every symbol clock cycle
// - sample from precoded power-scaled PAM symbol
// - payload sample don't-care during low power idle
// - light-off request on idle-payload after pad
// - delay light-off by scaling and framing latency
// - light-on request on pad after idle-payload
// - advance light-on by latency, hold it on for latency plus wake-up
// - advertise low power idle capability in header
// - received signal sampled continuously for recovery
// - no-light payload flagged idle, receiver may sleep
// - idle-payload type used only when negotiated
// - pad type marks zero-valued framing symbols
package eo_lpi_pkg;
  localparam int SYMB_W = 4;
  localparam int SAMPLE_W = 10;
  localparam int SCALE_W = 8;
  localparam int RX_W = 10;
  localparam int FIFO_DEPTH = 8;
  localparam int PIPE_LAT = 4;
  localparam int WAKE_CYCLES = 6;
  localparam int ADV = PIPE_LAT + WAKE_CYCLES;
  localparam int QUIET_CYCLES = 16;
  localparam logic [SCALE_W-1:0] SCALE_RST = 8'h80;
  localparam logic [RX_W-1:0] DARK_RST = 10'h020;

  // AXI4-Lite register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SCALE = 8'h04;
  localparam logic [7:0] ADDR_DARK = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // control fields
  localparam int CTRL_LPI_EN = 0;
  localparam int CTRL_RXPD_EN = 1;
  localparam int CTRL_PRECODE_EN = 2;
  // status fields
  localparam int STAT_TXPWR = 0;
  localparam int STAT_RXPWR = 1;
  localparam int STAT_RXIDLE = 2;
  localparam int STAT_CAP = 3;
  localparam int STAT_OVF = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    TY_S1 = 3'h0,
    TY_S2 = 3'h1,
    TY_HEADER = 3'h2,
    TY_ZERO = 3'h3,
    TY_PAYLOAD = 3'h4,
    TY_PAYLOAD_OFF = 3'h5
  } symbol_type_t;
endpackage

//--- design/sample_fifo.sv
// synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_t;
  fifo_state_t s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push, pop, full, empty;

  assign full = (s_q.wr[AW] != s_q.rd[AW]) && (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]);
  assign empty = s_q.wr == s_q.rd;
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign push = in_valid_in && !full;
  assign pop = out_ready_in && !empty;
  assign out_data_out = mem_q[s_q.rd[AW-1:0]];

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage without reset keeps the array out of the reset tree
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[s_q.wr[AW-1:0]] <= in_data_in;
    end
  end
endmodule

//--- design/lpi_edge_delay.sv
// fixed-length shift line for the power-scaling and framing latency
`timescale 1ns/100ps
module lpi_edge_delay #(
  parameter int WIDTH = 4,
  parameter int STAGES = 4
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  typedef struct packed {
    logic [STAGES-1:0][WIDTH-1:0] line;
  } line_state_t;
  line_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.line[0] = d_in;
    for (int i = 1; i < STAGES; i++) begin
      s_d.line[i] = s_q.line[i-1];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_out = s_q.line[STAGES-1];
endmodule

//--- design/eo_lpi_ctrl.sv
// transmit sample path and light power control toward the electro-optic unit
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module eo_lpi_ctrl
  import eo_lpi_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // transmit symbol stream from the coding/modulation block
  input wire logic [eo_lpi_pkg::SYMB_W-1:0] tx_symbol_in,
  input wire logic [2:0] tx_symbol_type_request_in,
  input wire logic tx_symbol_valid_in,
  output logic tx_symbol_ready_out,
  // toward the electro-optic unit
  output logic [eo_lpi_pkg::SAMPLE_W-1:0] tx_sample_transfer_out,
  output logic tx_light_power_request_out,
  output logic rx_conversion_power_request_out,
  input wire logic [eo_lpi_pkg::RX_W-1:0] rx_sample_transfer_in,
  // receive side indications
  output logic [eo_lpi_pkg::RX_W-1:0] rx_sample_out,
  output logic rx_payload_off_out,
  input wire logic rx_payload_window_in,
  output logic lpi_capable_out
);
  import eo_lpi_pkg::*;

  localparam int FW = SYMB_W + 3;

  typedef struct packed {
    logic [2:0] ctrl;
    logic [SCALE_W-1:0] scale;
    logic [RX_W-1:0] dark;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] prev_type;
    logic [SAMPLE_W-1:0] pre_d;
    logic [SAMPLE_W-1:0] sample;
    logic light_on;
    logic [4:0] on_cnt;
    logic ovf;
    logic [RX_W-1:0] rx_s1;
    logic [RX_W-1:0] rx_s2;
    logic win_s1;
    logic win_s2;
    logic [4:0] dark_cnt;
    logic rx_idle;
    logic rx_pwr;
  } state_t;
  state_t s_q, s_d;

  logic [FW-1:0] fifo_out;
  logic fifo_valid, fifo_in_ready;
  logic [FW-1:0] lat_out;
  logic [SYMB_W-1:0] sym;
  logic [2:0] typ, lat_typ;
  logic [SAMPLE_W-1:0] pam, precoded;
  logic [SAMPLE_W+SCALE_W-1:0] scaled;
  logic aw_fire, w_fire, ar_fire, off_edge, on_edge;

  // small elastic buffer between the coder and the symbol-clock sample stream
  sample_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(tx_symbol_valid_in),
    .in_ready_out(fifo_in_ready),
    .in_data_in({tx_symbol_type_request_in, tx_symbol_in}),
    .out_valid_out(fifo_valid),
    .out_ready_in(1'b1),
    .out_data_out(fifo_out)
  );
  assign tx_symbol_ready_out = fifo_in_ready;

  // models the power-scaling and frame-building pipeline
  lpi_edge_delay #(.WIDTH(FW), .STAGES(PIPE_LAT)) u_lat (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .d_in(fifo_valid ? fifo_out : {TY_PAYLOAD, {SYMB_W{1'b0}}}),
    .q_out(lat_out)
  );

  assign sym = fifo_out[SYMB_W-1:0];
  assign typ = fifo_valid ? fifo_out[FW-1:SYMB_W] : TY_PAYLOAD;
  assign lat_typ = lat_out[FW-1:SYMB_W];
  assign off_edge = (typ == TY_PAYLOAD_OFF) && (s_q.prev_type == TY_ZERO);
  assign on_edge = (typ == TY_ZERO) && (s_q.prev_type == TY_PAYLOAD_OFF);
  // PAM level centred on zero; pad symbols are forced to zero
  assign pam = (typ == TY_ZERO) ? '0 : SAMPLE_W'({sym, 1'b1}) - SAMPLE_W'(1 << SYMB_W);
  // modulo precoder: feeds back the previous output
  assign precoded = s_q.ctrl[CTRL_PRECODE_EN] ? pam - s_q.pre_d : pam;
  assign scaled = $signed(precoded) * $signed({1'b0, s_q.scale});

  assign aw_fire = s_axi_awvalid_in && s_axi_awready_out;
  assign w_fire = s_axi_wvalid_in && s_axi_wready_out;
  assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;
  assign s_axi_awready_out = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready_out = !s_q.w_got && !s_q.bvalid;
  assign s_axi_arready_out = !s_q.rvalid;

  always_comb begin
    s_d = s_q;
    // write channel, address and data in either order
    if (aw_fire) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr_in;
    end
    if (w_fire) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata_in;
      s_d.wstrb = s_axi_wstrb_in;
    end
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      unique case (s_q.awaddr)
        ADDR_CTRL: begin
          if (s_q.wstrb[0]) begin
            s_d.ctrl = s_q.wdata[2:0];
          end
        end
        ADDR_SCALE: begin
          if (s_q.wstrb[0]) begin
            s_d.scale = s_q.wdata[SCALE_W-1:0];
          end
        end
        ADDR_DARK: begin
          if (s_q.wstrb[0]) begin
            s_d.dark[7:0] = s_q.wdata[7:0];
          end
          if (s_q.wstrb[1]) begin
            s_d.dark[RX_W-1:8] = s_q.wdata[RX_W-1:8];
          end
        end
        ADDR_STATUS: begin
          // writing a one to the overflow bit clears the overflow flag, unless the FIFO is empty that cycle and sets it again
          if (s_q.wstrb[0] && s_q.wdata[STAT_OVF]) begin
            s_d.ovf = 1'b0;
          end
        end
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready_in) begin
      s_d.bvalid = 1'b0;
    end
    if (ar_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = '0;
      unique case (s_axi_araddr_in)
        ADDR_CTRL: s_d.rdata[2:0] = s_q.ctrl;
        ADDR_SCALE: s_d.rdata[SCALE_W-1:0] = s_q.scale;
        ADDR_DARK: s_d.rdata[RX_W-1:0] = s_q.dark;
        ADDR_STATUS: s_d.rdata[4:0] = {s_q.ovf, 1'b1, s_q.rx_idle, s_q.rx_pwr, s_q.light_on};
        default: s_d.rresp = RESP_SLVERR;
      endcase
    end else if (s_q.rvalid && s_axi_rready_in) begin
      s_d.rvalid = 1'b0;
    end

    // one sample per symbol clock; payload-off samples are don't-care, sent as zero
    s_d.prev_type = typ;
    s_d.pre_d = precoded;
    if (typ == TY_PAYLOAD_OFF) begin
      s_d.sample = '0;
    end else begin
      s_d.sample = scaled[SAMPLE_W+6:7];
    end
    if (!fifo_valid) begin
      s_d.ovf = 1'b1;
    end

    // light control; light-off requests only when low power idle is negotiated, else the request is held on
    if (!s_q.ctrl[CTRL_LPI_EN]) begin
      s_d.light_on = 1'b1;
      s_d.on_cnt = '0;
    end else begin
      // idle-payload symbol just came out of the pipeline: switch off on it
      if ((lat_typ == TY_PAYLOAD_OFF) && s_q.light_on && (s_q.on_cnt == '0)) begin
        s_d.light_on = 1'b0;
      end
      // light-on is raised early: the pad is seen PIPE_LAT cycles ahead of the fibre
      if (on_edge) begin
        s_d.light_on = 1'b1;
        s_d.on_cnt = 5'(ADV);
      end else if (s_q.on_cnt != '0) begin
        s_d.on_cnt = s_q.on_cnt - 1'b1;
      end
      if (off_edge) begin
        s_d.on_cnt = '0;
      end
    end

    // receive: continuous sampling through two flops
    s_d.rx_s1 = rx_sample_transfer_in;
    s_d.rx_s2 = s_q.rx_s1;
    s_d.win_s1 = rx_payload_window_in;
    s_d.win_s2 = s_q.win_s1;
    if (s_q.win_s2 && s_q.ctrl[CTRL_LPI_EN] && (s_q.rx_s2 < s_q.dark)) begin
      if (s_q.dark_cnt != 5'(QUIET_CYCLES)) begin
        s_d.dark_cnt = s_q.dark_cnt + 1'b1;
      end
    end else begin
      s_d.dark_cnt = '0;
    end
    s_d.rx_idle = s_q.dark_cnt == 5'(QUIET_CYCLES);
    // receiver wakes at window end, since no light can be seen while off
    s_d.rx_pwr = !(s_d.rx_idle && s_q.ctrl[CTRL_RXPD_EN] && s_q.win_s2);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
      s_q.scale <= SCALE_RST;
      s_q.dark <= DARK_RST;
      s_q.prev_type <= TY_PAYLOAD;
      s_q.light_on <= 1'b1;
      s_q.rx_pwr <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_bvalid_out = s_q.bvalid;
  assign s_axi_bresp_out = s_q.bresp;
  assign s_axi_rvalid_out = s_q.rvalid;
  assign s_axi_rdata_out = s_q.rdata;
  assign s_axi_rresp_out = s_q.rresp;
  assign tx_sample_transfer_out = s_q.sample;
  assign tx_light_power_request_out = s_q.light_on;
  assign rx_conversion_power_request_out = s_q.rx_pwr;
  assign rx_sample_out = s_q.rx_s2;
  assign rx_payload_off_out = s_q.rx_idle;
  assign lpi_capable_out = 1'b1;
endmodule

//--- sim/eo_lpi_ctrl_asserts.sv
// port assertions for the low power idle control block
`timescale 1ns/100ps
module eo_lpi_ctrl_asserts
  import eo_lpi_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [2:0] tx_symbol_type_request_in,
  input wire logic tx_symbol_valid_in,
  input wire logic tx_symbol_ready_out,
  input wire logic tx_light_power_request_out,
  input wire logic rx_conversion_power_request_out,
  input wire logic rx_payload_off_out,
  input wire logic rx_payload_window_in,
  input wire logic lpi_capable_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic [2:0] prev_q;
  logic [4:0] off_q;
  logic [4:0] on_q;
  logic [4:0] win_q;
  wire tk = tx_symbol_valid_in & tx_symbol_ready_out;
  wire [2:0] ty = tx_symbol_type_request_in;
  function automatic logic [4:0] sat(input logic [4:0] v);
    return (v == 5'h1F) ? v : v + 5'h01;
  endfunction
  // counters saturate so a missing cause shows as a large age
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev_q <= 3'h0;
      off_q <= 5'h1F;
      on_q <= 5'h1F;
      win_q <= 5'h00;
    end else begin
      if (tk) prev_q <= ty;
      off_q <= (tk && ty == TY_PAYLOAD_OFF && prev_q == TY_ZERO) ? 5'h00 : sat(off_q);
      on_q <= (tk && ty == TY_ZERO && prev_q == TY_PAYLOAD_OFF) ? 5'h00 : sat(on_q);
      win_q <= rx_payload_window_in ? sat(win_q) : 5'h00;
    end
  end
  sequence s_lit_held;
    tx_light_power_request_out [*8];
  endsequence
  sequence s_win_low;
    !rx_payload_window_in [*5];
  endsequence
  AST_CAP: assert property (lpi_capable_out)
    else $error("capability not advertised");
  AST_RST_ON: assert property (disable iff (1'b0)
    !nrst_in |-> tx_light_power_request_out && rx_conversion_power_request_out)
    else $error("requests not on in reset");
  AST_OFF_CAUSE: assert property ($fell(tx_light_power_request_out)
    |-> off_q >= 5'h02 && off_q <= 5'h0E) else $error("light off untimely");
  AST_ON_CAUSE: assert property ($rose(tx_light_power_request_out)
    |-> on_q <= 5'h04) else $error("light on untimely");
  AST_ON_HOLD: assert property ($rose(tx_light_power_request_out) |-> s_lit_held)
    else $error("light dropped during wake");
  AST_RX_WAIT: assert property ($rose(rx_payload_off_out) |-> win_q >= 5'h10)
    else $error("idle flagged too early");
  AST_RX_WIN_ON: assert property (s_win_low |-> rx_conversion_power_request_out)
    else $error("conversion off outside payload");
  AST_RX_FLAG: assert property ($fell(rx_conversion_power_request_out)
    |-> rx_payload_off_out) else $error("conversion off without idle");
endmodule
bind eo_lpi_ctrl eo_lpi_ctrl_asserts u_chk (
  .clk_in(clk_in),
  .nrst_in(nrst_in),
  .tx_symbol_type_request_in(tx_symbol_type_request_in),
  .tx_symbol_valid_in(tx_symbol_valid_in),
  .tx_symbol_ready_out(tx_symbol_ready_out),
  .tx_light_power_request_out(tx_light_power_request_out),
  .rx_conversion_power_request_out(rx_conversion_power_request_out),
  .rx_payload_off_out(rx_payload_off_out),
  .rx_payload_window_in(rx_payload_window_in),
  .lpi_capable_out(lpi_capable_out)
);

//--- sim/eo_unit_model.sv
// behavioural electro-optic unit at the far side
`timescale 1ns/100ps
module eo_unit_model (
  input wire logic clk_in,
  input wire logic light_req_in,
  input wire logic conv_req_in,
  input wire logic remote_dark_in,
  output logic light_on_out,
  output logic [9:0] rx_sample_out
);
  integer seed = 92;
  initial begin
    light_on_out = 1'h1;
    rx_sample_out = 10'h000;
  end
  // output is never held: fresh noise every cycle
  always @(posedge clk_in) begin
    light_on_out <= light_req_in;
    if (!conv_req_in || remote_dark_in) begin
      rx_sample_out <= {5'h00, 5'($random(seed))};
    end else begin
      rx_sample_out <= {1'h1, 9'($random(seed))};
    end
  end
endmodule

//--- sim/tb_top.sv
// self-checking bench for the low power idle control block
`timescale 1ns/100ps
module tb_top;
  import eo_lpi_pkg::*;
  logic clk_in = 1'h0;
  logic nrst_in = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic [3:0] sym = 4'h0;
  logic [2:0] ty = 3'h0;
  logic sv = 1'h0, win = 1'h0, dark = 1'h0;
  logic awr, wr, bv, arr, rv, srdy, lit, conv, roff, cap, lon;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic [9:0] rxs;
  logic [1:0] bresp;
  logic [9:0] smp, rxo, rx_h1, rx_h2;
  logic [33:0] exp_q[$];
  integer seed = 92;
  int miscompares = 0;
  int n_compared = 0;
  always #2.5 clk_in = ~clk_in;
  eo_lpi_ctrl dut (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rready),
    .tx_symbol_in(sym), .tx_symbol_type_request_in(ty), .tx_symbol_valid_in(sv),
    .tx_symbol_ready_out(srdy), .tx_sample_transfer_out(smp),
    .tx_light_power_request_out(lit), .rx_conversion_power_request_out(conv),
    .rx_sample_transfer_in(rxs), .rx_sample_out(rxo), .rx_payload_off_out(roff),
    .rx_payload_window_in(win), .lpi_capable_out(cap)
  );
  eo_unit_model u_eo (
    .clk_in(clk_in), .light_req_in(lit), .conv_req_in(conv),
    .remote_dark_in(dark), .light_on_out(lon), .rx_sample_out(rxs)
  );
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (e !== g) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // two-edge history of the far-side sample, as the synchroniser sees it
  always @(posedge clk_in) begin
    rx_h1 <= rxs;
    rx_h2 <= rx_h1;
  end
  // sampled at negedge: settled, and equal to what the next edge sees
  always @(negedge clk_in) begin
    if (rv && rready) begin
      chk("read", exp_q.pop_front(), {rresp, rdata});
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ta, tw, tb;
    logic [1:0] bg;
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    tb = 1'h0;
    while (!tb) begin
      @(negedge clk_in);
      ta = awr & awv;
      tw = wr & wv;
      tb = bv;
      bg = bresp;
      @(posedge clk_in);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
    end
    bready <= 1'h0;
    chk("bresp", {32'h0, e}, {32'h0, bg});
    @(posedge clk_in);
  endtask
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    logic ta, tr;
    exp_q.push_back(e);
    araddr <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    tr = 1'h0;
    while (!tr) begin
      @(negedge clk_in);
      ta = arr & arv;
      tr = rv;
      @(posedge clk_in);
      if (ta) arv <= 1'h0;
    end
    rready <= 1'h0;
    @(posedge clk_in);
  endtask
  // fifo drains every cycle, so ready is not waited on
  task automatic send(input logic [2:0] t, input int n);
    repeat (n) begin
      sv <= 1'h1;
      ty <= t;
      sym <= 4'($random(seed));
      @(posedge clk_in);
    end
  endtask
  initial begin
    nrst_in <= 1'h0;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'h1;
    @(posedge clk_in);
    #1;
    chk("light", 34'h1, {33'h0, lit});
    chk("conv", 34'h1, {33'h0, conv});
    chk("cap", 34'h1, {33'h0, cap});
    axr(ADDR_SCALE, {RESP_OKAY, 24'h0, SCALE_RST});
    axr(ADDR_DARK, {RESP_OKAY, 22'h0, DARK_RST});
    axr(ADDR_STATUS, {RESP_OKAY, 32'h1B});
    axr(8'h10, {RESP_SLVERR, 32'h0});
    axw(8'h10, 32'h0, RESP_SLVERR);
    for (int k = 0; k < 4; k++) begin
      axw(ADDR_CTRL, {30'h0, 1'h1, k[0]}, RESP_OKAY);
      axr(ADDR_CTRL, {RESP_OKAY, 30'h0, 1'h1, k[0]});
      for (int t = 0; t < 3; t++) send(3'(t), 2);
      send(TY_ZERO, 4);
      send(TY_PAYLOAD_OFF, 12);
      #1;
      chk("dark", {33'h0, !k[0]}, {33'h0, lit});
      chk("offsample", 34'h0, {24'h0, smp});
      chk("eo", {33'h0, lit}, {33'h0, lon});
      send(TY_ZERO, 4);
      #1;
      chk("relit", 34'h1, {33'h0, lit});
      chk("padsample", 34'h0, {24'h0, smp});
      send(TY_PAYLOAD, 6);
      sv <= 1'h0;
    end
    dark <= 1'h1;
    win <= 1'h1;
    repeat (30) @(posedge clk_in);
    #1;
    chk("rxoff", 34'h1, {33'h0, roff});
    chk("rxpwr", 34'h0, {33'h0, conv});
    chk("rxsample", {24'h0, rx_h2}, {24'h0, rxo});
    axr(ADDR_STATUS, {RESP_OKAY, 32'h1D});
    win <= 1'h0;
    dark <= 1'h0;
    repeat (8) @(posedge clk_in);
    #1;
    chk("rxon", 34'h1, {33'h0, conv});
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    miscompares++;
    report_and_stop();
  end
endmodule
